// ===== verilog/eio_pkg.sv
// Package for the expanded I/O port: register map, field layout,
// reset values and the bus carriers shared by all its modules.
// Assumes a single AHB-Lite slave with 32-bit data and word transfers.
package eio_pkg;

   // Byte offsets within the block's window
   localparam logic [3:0] EIO_OFS_CTL  = 4'h0;
   localparam logic [3:0] EIO_OFS_IN   = 4'h4;
   localparam logic [3:0] EIO_OFS_OUT  = 4'h8;
   localparam logic [3:0] EIO_OFS_DATA = 4'hc;

   // Field positions
   localparam int EIO_CTL_DIR_BIT = 3;
   localparam int EIO_CTL_EN_BIT  = 5;
   localparam int EIO_OUT_LSB     = 1;
   localparam int EIO_OUT_MSB     = 3;

   // Reset values
   localparam logic       EIO_DIR_RESET  = 1'b0;
   localparam logic       EIO_EN_RESET   = 1'b1;
   localparam logic [2:0] EIO_OUT_RESET  = 3'h0;
   localparam logic [7:0] EIO_DATA_RESET = 8'h00;
   localparam logic [4:0] EIO_IN_RESET   = 5'h00;
   localparam logic [2:0] EIO_IN_RSV     = 3'h2;

   // Register selected by an address
   typedef enum logic [1:0] {
      EIO_SEL_CTL  = 2'b00,
      EIO_SEL_IN   = 2'b01,
      EIO_SEL_OUT  = 2'b11,
      EIO_SEL_DATA = 2'b10
   } eio_sel_t;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } eio_ahb_in_t;

   typedef struct packed {
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
   } eio_ahb_out_t;

   typedef struct packed {
      logic     valid;
      logic     write;
      logic     hit;
      eio_sel_t sel;
   } eio_dphase_t;

   typedef struct packed {
      logic     hit;
      eio_sel_t sel;
   } eio_dec_t;

   // Address decode, used for both the address and the data phase
   function automatic eio_dec_t eio_decode(input logic [31:0] addr);
      eio_dec_t d;
      d.hit = (addr[31:4] == 28'h0000000) && (addr[1:0] == 2'h0);
      d.sel = EIO_SEL_CTL;
      unique case (addr[3:0])
         EIO_OFS_CTL:  d.sel = EIO_SEL_CTL;
         EIO_OFS_IN:   d.sel = EIO_SEL_IN;
         EIO_OFS_OUT:  d.sel = EIO_SEL_OUT;
         EIO_OFS_DATA: d.sel = EIO_SEL_DATA;
         default:      d.hit = 1'b0;
      endcase
      return d;
   endfunction

endpackage

// ===== verilog/eio_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to sys_clk; no glitch filtering.
`timescale 1ns/1ps
module eio_sync
   import eio_pkg::*;
#(
   parameter int WIDTH = 8
)(
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } eio_sync_state_t;

   eio_sync_state_t st_reg;
   eio_sync_state_t st_next;

   always_comb
   begin
      st_next      = st_reg;
      st_next.meta = async_in;
      st_next.sync = st_reg.meta;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign sync_out = st_reg.sync;

endmodule // eio_sync

// ===== verilog/eio_ahb_front.sv
// AHB-Lite address-phase capture for the expanded I/O port.
// Assumes the slave is always ready, so hready alone gates acceptance.
`timescale 1ns/1ps
module eio_ahb_front
   import eio_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire eio_ahb_in_t ahb_in,
   output logic             accept,
   output eio_dec_t         addr_dec,
   output eio_dphase_t      dphase
);

   eio_dphase_t st_reg;
   eio_dphase_t st_next;

   // NONSEQ or SEQ both count; only singles are expected
   assign accept   = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
   assign addr_dec = eio_decode(ahb_in.haddr);

   always_comb
   begin
      st_next       = st_reg;
      if (ahb_in.hready)
      begin
         st_next.valid = accept;
         st_next.write = accept && ahb_in.hwrite;
         st_next.hit   = addr_dec.hit;
         st_next.sel   = addr_dec.sel;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign dphase = st_reg;

endmodule // eio_ahb_front

// ===== verilog/eio_port.sv
// Expanded I/O port: control, input sample, output drive and data
// registers behind an AHB-Lite slave, plus the pin logic they steer.
// Assumes pins are asynchronous; the bidirectional wire is resolved
// outside from port_out and port_oe.
//
// Notes on behaviour
// - In output direction a data write puts the byte on the eight pins.
// - In input direction a data read returns the sampled pin byte.
// - Control bit 3 is direction, resets to 0: 0 output, 1 input.
// - Control bit 5 enables input sampling, resets to 1.
// - Reserved control bits read zero; software writes zero there.
// - Input sample bits 4, 5, 7 follow their lines unchanged.
// - Input sample bits 3 and 6 return their lines inverted.
// - Output bits 1 to 3 drive their pins inverted; one pulls low.
// - Output bits reset to zero, so the three pins rest high.
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
module eio_port
   import eio_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire eio_ahb_in_t ahb_in,
   output eio_ahb_out_t     ahb_out,
   input  wire logic [7:0]  port_in,
   output logic      [7:0]  port_out,
   output logic      [7:0]  port_oe,
   input  wire logic [7:3]  input_lines,
   output logic      [3:1]  output_lines_n
);

   ////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic       dir;
      logic       in_en;
      logic [4:0] in_sample;
      logic [2:0] out_bits;
      logic [2:0] out_pins_n;
      logic [7:0] data_wr;
      logic [7:0] pin_out;
      logic [7:0] pin_oe;
      logic [31:0] hrdata;
      logic       hready;
      logic       hresp;
   } eio_state_t;

   localparam eio_state_t EIO_STATE_RESET = '{
      dir:        EIO_DIR_RESET,
      in_en:      EIO_EN_RESET,
      in_sample:  EIO_IN_RESET,
      out_bits:   EIO_OUT_RESET,
      out_pins_n: ~EIO_OUT_RESET,
      data_wr:    EIO_DATA_RESET,
      pin_out:    EIO_DATA_RESET,
      pin_oe:     {8{~EIO_DIR_RESET}},
      hrdata:     32'h00000000,
      hready:     1'b1,
      hresp:      1'b0
   };

   eio_state_t  st_reg;
   eio_state_t  st_next;
   logic        accept;
   eio_dec_t    addr_dec;
   eio_dphase_t dphase;
   logic [7:0]  port_sync;
   logic [7:3]  lines_sync;

   ////////////////////////////////////////////////////////////////////
   // Bus front end and synchronisers

   eio_ahb_front u_front (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .ahb_in   (ahb_in),
      .accept   (accept),
      .addr_dec (addr_dec),
      .dphase   (dphase)
   );

   eio_sync #(.WIDTH(8)) u_port_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in (port_in),
      .sync_out (port_sync)
   );

   eio_sync #(.WIDTH(5)) u_line_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in (input_lines),
      .sync_out (lines_sync)
   );

   ////////////////////////////////////////////////////////////////////
   // Read mux

   function automatic logic [31:0] eio_read(input eio_sel_t   sel,
                                            input eio_state_t s,
                                            input logic [7:0] pins);
      logic [7:0] b;
      b = 8'h00;
      unique case (sel)
         EIO_SEL_CTL:
         begin
            b[EIO_CTL_DIR_BIT] = s.dir;
            b[EIO_CTL_EN_BIT]  = s.in_en;
         end
         EIO_SEL_IN:   b = {s.in_sample, EIO_IN_RSV};
         EIO_SEL_OUT:  b[EIO_OUT_MSB:EIO_OUT_LSB] = s.out_bits;
         EIO_SEL_DATA: b = s.dir ? pins : s.data_wr;
      endcase
      return {24'h000000, b};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      st_next        = st_reg;
      st_next.hready = 1'b1;
      st_next.hresp  = 1'b0;

      // Data phase of a write; reserved bits are dropped, so they read 0
      if (dphase.valid && dphase.write && dphase.hit)
      begin
         unique case (dphase.sel)
            EIO_SEL_CTL:
            begin
               st_next.dir   = ahb_in.hwdata[EIO_CTL_DIR_BIT];
               st_next.in_en = ahb_in.hwdata[EIO_CTL_EN_BIT];
            end
            EIO_SEL_IN:   st_next.dir = st_reg.dir;
            EIO_SEL_OUT:  st_next.out_bits = ahb_in.hwdata[EIO_OUT_MSB:EIO_OUT_LSB];
            EIO_SEL_DATA: st_next.data_wr = ahb_in.hwdata[7:0];
         endcase
      end

      // Sampling freezes while input mode is disabled
      if (st_reg.in_en)
      begin
         st_next.in_sample = {lines_sync[7], ~lines_sync[6],
                              lines_sync[5], lines_sync[4], ~lines_sync[3]};
      end

      st_next.out_pins_n = ~st_next.out_bits;
      st_next.pin_out    = st_next.data_wr;
      st_next.pin_oe     = {8{~st_next.dir}};

      // Read data built from the next state, so a read right behind a
      // write already sees it
      if (accept && !ahb_in.hwrite && addr_dec.hit)
         st_next.hrdata = eio_read(addr_dec.sel, st_next, port_sync);
      else
         st_next.hrdata = 32'h00000000;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         st_reg <= EIO_STATE_RESET;
      else
         st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   assign ahb_out.hreadyout = st_reg.hready;
   assign ahb_out.hresp     = st_reg.hresp;
   assign ahb_out.hrdata    = st_reg.hrdata;
   assign port_out          = st_reg.pin_out;
   assign port_oe           = st_reg.pin_oe;
   assign output_lines_n    = st_reg.out_pins_n;

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Plain booleans for the write phases, since a sequence cannot be negated
   logic wr_phase;
   logic wr_data_ph;
   logic wr_ctl_ph;
   logic wr_out_ph;

   assign wr_phase   = dphase.valid && dphase.write && dphase.hit;
   assign wr_data_ph = wr_phase && dphase.sel == EIO_SEL_DATA;
   assign wr_ctl_ph  = wr_phase && dphase.sel == EIO_SEL_CTL;
   assign wr_out_ph  = wr_phase && dphase.sel == EIO_SEL_OUT;

   sequence s_wr_data;
      wr_data_ph;
   endsequence

   sequence s_wr_ctl;
      wr_ctl_ph;
   endsequence

   sequence s_wr_out;
      wr_out_ph;
   endsequence

   sequence s_rd(eio_sel_t s);
      accept && !ahb_in.hwrite && addr_dec.hit && addr_dec.sel == s;
   endsequence

   chk_data_drives_pins: assert property (
      (s_wr_data and !st_reg.dir)
      |=> port_out == $past(ahb_in.hwdata[7:0]) && port_oe == 8'hff)
      else $error("data write did not reach the port pins");

   chk_input_read_pins: assert property (
      (s_rd(EIO_SEL_DATA) and st_reg.dir && !wr_ctl_ph)
      |=> ahb_out.hrdata == {24'h000000, $past(port_sync)})
      else $error("input direction read did not return pin byte");

   chk_dir_write: assert property (
      s_wr_ctl |=> st_reg.dir == $past(ahb_in.hwdata[EIO_CTL_DIR_BIT])
                   && port_oe == {8{~$past(ahb_in.hwdata[EIO_CTL_DIR_BIT])}})
      else $error("direction bit did not follow control write");

   chk_ctl_reserved_zero: assert property (
      s_rd(EIO_SEL_CTL) |=> (ahb_out.hrdata & 32'hffffffd7) == 32'h00000000)
      else $error("reserved control bits read non-zero");

   chk_sample_frozen: assert property (
      !st_reg.in_en && !wr_ctl_ph |=> $stable(st_reg.in_sample) [*2])
      else $error("input sample changed while disabled");

   chk_sample_plain: assert property (
      st_reg.in_en |=> st_reg.in_sample[4] == $past(lines_sync[7])
                       && st_reg.in_sample[2:1] == $past(lines_sync[5:4]))
      else $error("plain input bits do not follow their lines");

   chk_sample_invert: assert property (
      st_reg.in_en |=> st_reg.in_sample[3] == !$past(lines_sync[6])
                       && st_reg.in_sample[0] == !$past(lines_sync[3]))
      else $error("inverted input bits do not follow their lines");

   chk_out_pins_inverted: assert property (
      s_wr_out |=> output_lines_n == ~$past(ahb_in.hwdata[EIO_OUT_MSB:EIO_OUT_LSB]))
      else $error("output pins not inverse of written bits");

   chk_out_hold: assert property (
      !wr_out_ph |=> $stable(output_lines_n))
      else $error("output pins moved without a write");

   chk_readback_written: assert property (
      (s_wr_data and !st_reg.dir) ##1 (s_rd(EIO_SEL_DATA) and !st_reg.dir && !wr_ctl_ph)
      |=> ahb_out.hrdata[7:0] == $past(ahb_in.hwdata[7:0], 2))
      else $error("output direction read did not return written byte");

   chk_release_input: assert property (
      st_reg.dir |-> port_oe == 8'h00)
      else $error("pins driven in input direction");

   chk_bus_okay: assert property (
      ahb_out.hreadyout && !ahb_out.hresp)
      else $error("slave stalled or answered with an error");

   chk_en_write: assert property (
      s_wr_ctl |=> st_reg.in_en == $past(ahb_in.hwdata[EIO_CTL_EN_BIT]))
      else $error("input mode enable did not follow control write");

   chk_ctl_readback: assert property (
      s_rd(EIO_SEL_CTL) and !wr_ctl_ph
      |=> ahb_out.hrdata[EIO_CTL_DIR_BIT] == !$past(port_oe[0]))
      else $error("direction bit read back does not match the pins");

   chk_out_readback: assert property (
      s_rd(EIO_SEL_OUT) and !wr_out_ph
      |=> ahb_out.hrdata == {28'h0000000, ~$past(output_lines_n), 1'b0})
      else $error("output register read does not match its pins");

   chk_pins_hold: assert property (
      !wr_data_ph && !wr_ctl_ph |=> $stable(port_out) && $stable(port_oe))
      else $error("port pins moved without a data or control write");

   chk_input_no_drive: assert property (
      s_wr_data and st_reg.dir |=> port_oe == 8'h00)
      else $error("data write drove the pins in input direction");

   chk_in_ignored: assert property (
      wr_phase && dphase.sel == EIO_SEL_IN
      |=> $stable(port_oe) && $stable(port_out) && $stable(output_lines_n))
      else $error("write to the input register changed an output");

   chk_in_reserved: assert property (
      s_rd(EIO_SEL_IN) |=> ahb_out.hrdata[2:0] == EIO_IN_RSV
                            && ahb_out.hrdata[31:8] == 24'h000000)
      else $error("input register fixed bits read wrong");

   chk_unmapped_zero: assert property (
      accept && !ahb_in.hwrite && !addr_dec.hit |=> ahb_out.hrdata == 32'h00000000)
      else $error("unmapped read returned non-zero data");

   chk_rdata_idle: assert property (
      !(accept && !ahb_in.hwrite) |=> ahb_out.hrdata == 32'h00000000)
      else $error("read data stood beyond its data phase");

endmodule // eio_port

// ===== tb/eio_pins.sv
// Board-side model of the eight bidirectional pins of the expanded I/O port.
// Assumes the bench sets ext_val/ext_en; the port's own enable wins on a bit.
`timescale 1ns/1ps
module eio_pins
(
   input  wire logic       sys_clk,
   input  wire logic [7:0] port_out,
   input  wire logic [7:0] port_oe,
   input  wire logic [7:0] ext_val,
   input  wire logic       ext_en,
   output logic      [7:0] port_in
);
   logic [7:0] held;

   // No pull on these pins: a released wire flips every cycle, never holds
   always @(posedge sys_clk) held <= ~port_in;

   always_comb
   begin
      for (int i = 0; i < 8; i++)
         port_in[i] = port_oe[i] ? port_out[i] : (ext_en ? ext_val[i] : held[i]);
   end
endmodule // eio_pins

// ===== tb/tb_top.sv
// Self-checking bench for the expanded I/O port behind AHB-Lite.
// Assumes a zero-wait slave; the board model resolves the pin wire.
`timescale 1ns/1ps
module tb_top;
   import eio_pkg::*;

   typedef struct packed {
      logic [31:0] a;
      logic [7:0]  wd;
      logic [7:0]  rd;
      logic [7:0]  pins;
      logic [2:0]  ln;
   } eio_row_t;

   logic         sys_clk;
   logic         rst;
   eio_ahb_in_t  ahb_in;
   eio_ahb_in_t  ahb_dut;
   eio_ahb_out_t ahb_out;
   logic [7:0]   port_in;
   logic [7:0]   port_out;
   logic [7:0]   port_oe;
   logic [7:0]   ext_val;
   logic         ext_en;
   logic [7:3]   input_lines;
   logic [3:1]   output_lines_n;
   logic [31:0]  rd;
   int           errors;
   int           total_checks;
   eio_row_t     rows [7];

   eio_port dut (.sys_clk(sys_clk), .rst(rst), .ahb_in(ahb_dut), .ahb_out(ahb_out),
                 .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
                 .input_lines(input_lines), .output_lines_n(output_lines_n));
   eio_pins pins (.sys_clk(sys_clk), .port_out(port_out), .port_oe(port_oe),
                  .ext_val(ext_val), .ext_en(ext_en), .port_in(port_in));

   // The one slave's hreadyout is the bus hready; one driver for the carrier
   always_comb
   begin
      ahb_dut        = ahb_in;
      ahb_dut.hready = ahb_out.hreadyout;
   end

   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task results;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task wait_ready;
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end while (ahb_out.hreadyout !== 1'b1 && n < 50);
      if (ahb_out.hreadyout !== 1'b1)
      begin
         errors++;
         results();
      end
   endtask

   // One single word transfer; read data is taken at the edge ending the data phase
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      ahb_in.hsel   <= 1'b1;
      ahb_in.htrans <= 2'b10;
      ahb_in.haddr  <= a;
      ahb_in.hwrite <= wr;
      ahb_in.hsize  <= 3'h2;
      wait_ready();
      ahb_in.htrans <= 2'b00;
      ahb_in.hwdata <= wd;
      wait_ready();
      rd = ahb_out.hrdata;
   endtask

   task chk_rd(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: read %h expected %h", $time, got, exp);
      end
   endtask

   // Pins are read at an edge as they stood before it; arguments are copied
   // on entry, so after a write the caller lets one more edge pass first
   task chk_pin(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: pins %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [31:0] a, input logic [7:0] d);
      ahb(1'b1, a, {24'h000000, d});
   endtask

   task rdc(input logic [31:0] a, input logic [7:0] exp);
      ahb(1'b0, a, 32'h00000000);
      chk_rd(rd, {24'h000000, exp});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      ahb_in = '0;
      ext_val = 8'h00;
      ext_en = 1'b0;
      input_lines = 5'h00;
      errors = 0;
      total_checks = 0;
      rows[0] = '{32'h8, 8'h0e, 8'h0e, 8'h00, 3'b000};
      rows[1] = '{32'h8, 8'h02, 8'h02, 8'h00, 3'b110};
      rows[2] = '{32'h8, 8'h0c, 8'h0c, 8'h00, 3'b001};
      rows[3] = '{32'hc, 8'ha5, 8'ha5, 8'ha5, 3'b001};
      rows[4] = '{32'hc, 8'h3c, 8'h3c, 8'h3c, 3'b001};
      rows[5] = '{32'h20, 8'hff, 8'h00, 8'h3c, 3'b001};
      // Lines all low: bits 3 and 6 read one, reserved field reads 010
      rows[6] = '{32'h4, 8'hff, 8'h4a, 8'h3c, 3'b001};
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk_pin({5'h00, output_lines_n}, 8'h07);
      chk_pin(port_oe, 8'hff);
      rdc(EIO_OFS_CTL, 8'h20);
      rdc(EIO_OFS_OUT, 8'h00);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].wd);
         rdc(rows[i].a, rows[i].rd);
         chk_pin(port_in, rows[i].pins);
         chk_pin({5'h00, output_lines_n}, {5'h00, rows[i].ln});
      end
      input_lines <= 5'b10101;
      repeat (4) @(posedge sys_clk);
      rdc(EIO_OFS_IN, 8'he2);
      input_lines <= 5'b01010;
      repeat (4) @(posedge sys_clk);
      rdc(EIO_OFS_IN, 8'h1a);
      wr(EIO_OFS_CTL, 8'h00);
      input_lines <= 5'b10101;
      repeat (4) @(posedge sys_clk);
      rdc(EIO_OFS_IN, 8'h1a);
      rdc(EIO_OFS_CTL, 8'h00);
      wr(EIO_OFS_CTL, 8'h28);
      @(posedge sys_clk);
      chk_pin(port_oe, 8'h00);
      ext_en <= 1'b1;
      ext_val <= 8'h5a;
      repeat (4) @(posedge sys_clk);
      rdc(EIO_OFS_DATA, 8'h5a);
      wr(EIO_OFS_DATA, 8'h77);
      @(posedge sys_clk);
      chk_pin(port_in, 8'h5a);
      ext_en <= 1'b0;
      wr(EIO_OFS_CTL, 8'h20);
      @(posedge sys_clk);
      chk_pin(port_in, 8'h77);
      rdc(EIO_OFS_DATA, 8'h77);
      wr(EIO_OFS_OUT, 8'h0e);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk_pin({5'h00, output_lines_n}, 8'h07);
      rdc(EIO_OFS_CTL, 8'h20);
      rdc(EIO_OFS_DATA, 8'h00);
      results();
   end
endmodule // tb_top
